// [common/ebt_map.vh]
`ifndef EBT_MAP_VH
`define EBT_MAP_VH
// register offsets (index on the plain register port)
`define EBT_REG_CTRL 4'h0
`define EBT_REG_SELECT 4'h1
`define EBT_REG_DELAY 4'h2
`define EBT_REG_TRMODE 4'h3
`define EBT_REG_QUAL 4'h4
`define EBT_REG_WIN_EN 4'h5
`define EBT_REG_WIN_DIS 4'h6
`define EBT_REG_STATUS 4'h7
`define EBT_REG_TRPTR 4'h8
`define EBT_REG_TRIGPTR 4'h9
`define EBT_REG_COND_BASE 4'ha
// condition register fields: data conditions use addr[11:0], type[13:12], value[21:14]
`define EBT_CD_ADDR_LSB 0
`define EBT_CD_TYPE_LSB 12
`define EBT_CD_VAL_LSB 14
// ctrl register bits (write-one actions and run mode)
`define EBT_CTRL_MODE_LSB 0
`define EBT_CTRL_START 2
`define EBT_CTRL_HALT 3
`define EBT_CTRL_CLEAR 4
`define EBT_CTRL_STEP 5
`define EBT_CTRL_PROC 6
// run modes
`define EBT_MODE_FREE 2'h0
`define EBT_MODE_COND 2'h1
`define EBT_MODE_STEP 2'h2
// trace modes
`define EBT_TM_ALL 2'h0
`define EBT_TM_QUAL 2'h1
`define EBT_TM_SECT 2'h2
// access types
`define EBT_ACC_READ 2'h1
`define EBT_ACC_WRITE 2'h2
`define EBT_ACC_RMW 2'h3
`define EBT_ACC_ANY 2'h0
// trace memory
`define EBT_TR_LAST 11'h7ff
`define EBT_TR_HALF 11'h400
`define EBT_DELAY_RST 11'h000
`endif

// [hw/ebt_break_trace.v]
// Operation
// - event breaks only in conditional run
// - only selected condition registers act
// - four data, two program conditions
// - plain halt only during real-time run
// - halt-and-clear stops and resets target
// - invalid access terminates in every mode
// - trace memory fills circularly, wraps
// - free run: tracer stops after delay
// - conditional run: target stops, enters step
// - step clears trace, records one instruction
// - unconditional mode records every instruction
// - qualified mode records on condition match
// - sectional window: enable starts, disable ends
// - one trace mode, last write governs
// - procedure call runs untraced, unbroken
// - frame holds addresses, data, port, clip
// - access type read/write/rmw, wildcard match
// - middle delay centres trigger frame
// - trace pointer is 11-bit frame number
`timescale 1ns/10ps
`include "ebt_map.vh"
module ebt_break_trace (
    input wire clk_sys,
    input wire rst,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    input wire tgt_insn_done,
    input wire tgt_is_call,
    input wire tgt_is_ret,
    input wire [15:0] program_address_field,
    input wire [7:0] program_word_field,
    input wire tgt_data_valid,
    input wire [11:0] data_address_field,
    input wire [7:0] data_value_field,
    input wire [1:0] access_type_field,
    input wire [3:0] port_value_field,
    input wire [7:0] clip_input_field,
    input wire tgt_invalid_access,
    output reg tgt_run_q,
    output reg tgt_reset_q,
    output reg tracing_q,
    input wire [10:0] rd_frame,
    output reg [57:0] rd_frame_data_q
);
    // ----------------------------------------------------------------
    // state and registers
    // ----------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_STEP = 2'h2;
    localparam ST_PROC = 2'h3;
    // run control: which phase the emulation is in and which run was asked for
    reg [1:0] state_q;
    reg [1:0] mode_q;
    // software-visible configuration, loaded over the register port
    reg [5:0] event_select_register;
    reg [10:0] trigger_delay_setting;
    reg [1:0] trace_mode_select;
    reg [5:0] qualified_trace_select;
    reg [5:0] win_en_q;
    reg [5:0] win_dis_q;
    reg [21:0] cond_q [0:5];
    // sectional window, trigger latch and delay countdown
    reg win_open_q;
    reg triggered_q;
    reg [10:0] delay_cnt_q;
    // write pointer; it also serves as the frame number read back by software
    reg [10:0] wptr_q;
    reg [10:0] trig_ptr_q;
    // last stop reason and call nesting inside a procedure run
    reg [2:0] stop_cause_q;
    // nesting is counted in two bits; a fourth nested call in a procedure wraps the count back to zero
    reg [1:0] proc_depth_q;
    // one frame per recorded access; the array wraps at the last index
    reg [57:0] trace_mem [0:2047];
    // per-frame valid bits make a step's erase a single-cycle action
    // instead of a 2048-cycle sweep of the array
    reg [2047:0] valid_q;
    // ----------------------------------------------------------------
    // condition matching
    // ----------------------------------------------------------------
    // data condition: address equal, type equal or wildcard, value equal
    // a type of zero in the condition accepts any access
    function data_hit;
        input [21:0] c;
        input [11:0] a;
        input [1:0] t;
        input [7:0] v;
        begin
            data_hit = (c[11:0] == a) && (c[21:14] == v) &&
                ((c[13:12] == `EBT_ACC_ANY) || (c[13:12] == t));
        end
    endfunction
    // register port index to condition slot; slot 6 means not a condition
    function [2:0] cond_slot;
        input [3:0] a;
        reg [3:0] d;
        begin
            d = a - `EBT_REG_COND_BASE;
            cond_slot = (a >= `EBT_REG_COND_BASE) ? d[2:0] : 3'h6;
        end
    endfunction
    // decoded once, shared by the write and the read side
    wire [2:0] slot = cond_slot(reg_addr);
    wire [5:0] hit;
    genvar gi;
    generate
        // slots 0-3 watch data accesses
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_data
            assign hit[gi] = tgt_data_valid && data_hit(cond_q[gi], data_address_field,
                access_type_field, data_value_field);
        end
        // slots 4-5 watch program fetches
        for (gi = 4; gi < 6; gi = gi + 1) begin : g_prog
            assign hit[gi] = tgt_insn_done &&
                (cond_q[gi][15:0] == program_address_field);
        end
    endgenerate
    // events and tracing are blind while a called procedure runs
    wire in_proc = (state_q == ST_PROC);
    wire event_hit = |(hit & event_select_register) && !in_proc;
    // ----------------------------------------------------------------
    // trace qualification
    // ----------------------------------------------------------------
    // only one mode governs recording at a time
    reg rec;
    always @* begin
        case (trace_mode_select)
            `EBT_TM_QUAL: rec = |(hit & qualified_trace_select);
            `EBT_TM_SECT: rec = tgt_insn_done &&
                (win_open_q || |(hit & win_en_q));
            default: rec = tgt_insn_done;
        endcase
    end
    // nothing is written while the tracer is stopped
    wire do_rec = tracing_q && !in_proc && rec && (tgt_insn_done || tgt_data_valid);
    // one frame: program side first, then data side, port and clip
    wire [57:0] frame = {program_address_field, program_word_field, data_address_field,
        data_value_field, access_type_field, port_value_field, clip_input_field};
    // ----------------------------------------------------------------
    // register writes and control
    // ----------------------------------------------------------------
    // control decodes shared by the run logic
    wire wr_ctrl = reg_wr && (reg_addr == `EBT_REG_CTRL);
    wire running = (state_q == ST_RUN);
    wire delay_done = triggered_q && (delay_cnt_q == 11'h000);
    integer k;
    always @(posedge clk_sys) begin
        if (rst) begin
            // everything quiet and idle; the target stays stopped
            state_q <= ST_IDLE;
            mode_q <= `EBT_MODE_FREE;
            event_select_register <= 6'h00;
            trigger_delay_setting <= `EBT_DELAY_RST;
            trace_mode_select <= `EBT_TM_ALL;
            qualified_trace_select <= 6'h00;
            win_en_q <= 6'h00;
            win_dis_q <= 6'h00;
            for (k = 0; k < 6; k = k + 1) cond_q[k] <= 22'h000000;
            win_open_q <= 1'b0;
            triggered_q <= 1'b0;
            delay_cnt_q <= 11'h000;
            wptr_q <= 11'h000;
            trig_ptr_q <= 11'h000;
            stop_cause_q <= 3'h0;
            proc_depth_q <= 2'h0;
            valid_q <= {2048{1'b0}};
            tgt_run_q <= 1'b0;
            tgt_reset_q <= 1'b0;
            tracing_q <= 1'b0;
        end else begin
            // the target reset is a one-cycle pulse by default
            tgt_reset_q <= 1'b0;
            // configuration writes; the last trace mode write wins
            if (reg_wr) begin
                case (reg_addr)
                    `EBT_REG_SELECT: event_select_register <= reg_wdata[5:0];
                    `EBT_REG_DELAY: trigger_delay_setting <= reg_wdata[10:0];
                    `EBT_REG_TRMODE: trace_mode_select <= reg_wdata[1:0];
                    `EBT_REG_QUAL: qualified_trace_select <= reg_wdata[5:0];
                    `EBT_REG_WIN_EN: win_en_q <= reg_wdata[5:0];
                    `EBT_REG_WIN_DIS: win_dis_q <= reg_wdata[5:0];
                    default: begin
                        if (slot != 3'h6)
                            cond_q[slot] <= reg_wdata[21:0];
                    end
                endcase
            end
            // sectional window: disable wins when both match together
            if (tracing_q && |(hit & win_dis_q))
                win_open_q <= 1'b0;
            else if (tracing_q && |(hit & win_en_q))
                win_open_q <= 1'b1;
            // ------------------------------------------------------------
            // trace write
            // ------------------------------------------------------------
            // the pointer wraps, so the oldest frame is the one lost
            if (do_rec) begin
                trace_mem[wptr_q] <= frame;
                valid_q[wptr_q] <= 1'b1;
                wptr_q <= (wptr_q == `EBT_TR_LAST) ? 11'h000 : wptr_q + 11'h001;
            end
            // ------------------------------------------------------------
            // trigger and delay
            // ------------------------------------------------------------
            // first selected event latches the trigger; delay counts recorded frames
            if (tracing_q && event_hit && !triggered_q) begin
                triggered_q <= 1'b1;
                trig_ptr_q <= wptr_q;
                delay_cnt_q <= trigger_delay_setting;
            end else if (triggered_q && do_rec && delay_cnt_q != 11'h000)
                delay_cnt_q <= delay_cnt_q - 11'h001;
            // delay point reached: tracer stops, in conditional run the target too
            if (tracing_q && delay_done && running) begin
                tracing_q <= 1'b0;
                triggered_q <= 1'b0;
                stop_cause_q <= 3'h1;
                if (mode_q == `EBT_MODE_COND) begin
                    tgt_run_q <= 1'b0;
                    state_q <= ST_STEP;
                end
            end
            // ------------------------------------------------------------
            // run control
            // ------------------------------------------------------------
            // procedure call from step mode runs the callee unobserved
            if (state_q == ST_PROC && tgt_insn_done) begin
                if (tgt_is_call)
                    proc_depth_q <= proc_depth_q + 2'h1;
                else if (tgt_is_ret) begin
                    if (proc_depth_q == 2'h0) begin
                        tgt_run_q <= 1'b0;
                        state_q <= ST_STEP;
                    end else
                        proc_depth_q <= proc_depth_q - 2'h1;
                end
            end
            // single step finishes after one instruction
            if (state_q == ST_STEP && tgt_run_q && tgt_insn_done) begin
                tgt_run_q <= 1'b0;
                tracing_q <= 1'b0;
            end
            if (wr_ctrl) begin
                // start only from idle; a step-mode start leaves the target waiting
                if (reg_wdata[`EBT_CTRL_START] && state_q == ST_IDLE) begin
                    mode_q <= reg_wdata[1:0];
                    state_q <= (reg_wdata[1:0] == `EBT_MODE_STEP) ? ST_STEP : ST_RUN;
                    tgt_run_q <= (reg_wdata[1:0] != `EBT_MODE_STEP);
                    tracing_q <= (reg_wdata[1:0] != `EBT_MODE_STEP);
                    win_open_q <= 1'b0;
                    triggered_q <= 1'b0;
                    stop_cause_q <= 3'h0;
                end
                if (reg_wdata[`EBT_CTRL_STEP] && state_q == ST_STEP && !tgt_run_q) begin
                    // each step wipes the buffer so only this instruction remains
                    valid_q <= {2048{1'b0}};
                    wptr_q <= 11'h000;
                    tgt_run_q <= 1'b1;
                    if (reg_wdata[`EBT_CTRL_PROC] && tgt_is_call) begin
                        state_q <= ST_PROC;
                        proc_depth_q <= 2'h0;
                    end else
                        tracing_q <= 1'b1;
                end
                // plain halt is ignored outside a real-time run
                if (reg_wdata[`EBT_CTRL_HALT] && running) begin
                    tgt_run_q <= 1'b0;
                    tracing_q <= 1'b0;
                    state_q <= ST_IDLE;
                    stop_cause_q <= 3'h2;
                end
                // halt-and-clear also pulses the target reset
                if (reg_wdata[`EBT_CTRL_CLEAR]) begin
                    tgt_run_q <= 1'b0;
                    tracing_q <= 1'b0;
                    tgt_reset_q <= 1'b1;
                    state_q <= ST_IDLE;
                    stop_cause_q <= 3'h3;
                end
            end
            // ------------------------------------------------------------
            // break sources
            // ------------------------------------------------------------
            // invalid access overrides everything, no delay; honoured from idle too,
            // so a start in the same cycle cannot slip past it
            if (tgt_invalid_access) begin
                tgt_run_q <= 1'b0;
                tracing_q <= 1'b0;
                triggered_q <= 1'b0;
                state_q <= ST_IDLE;
                stop_cause_q <= 3'h4;
            end
        end
    end
    // ----------------------------------------------------------------
    // status word
    // ----------------------------------------------------------------
    // cause codes: 1 delay point, 2 plain halt, 3 halt-and-clear, 4 invalid access
    wire [31:0] status_word = {22'h0, win_open_q, triggered_q, stop_cause_q,
        tracing_q, tgt_run_q, state_q, 1'b0};
    // ----------------------------------------------------------------
    // read side
    // ----------------------------------------------------------------
    // frame read port; invalid (erased) frames read as zero
    always @(posedge clk_sys) begin
        if (rst)
            rd_frame_data_q <= 58'h0;
        else
            rd_frame_data_q <= valid_q[rd_frame] ? trace_mem[rd_frame] : 58'h0;
    end
    // register read port: data for one cycle after the strobe, zero otherwise
    always @(posedge clk_sys) begin
        if (rst)
            reg_rdata_q <= 32'h0;
        else if (reg_rd) begin
            case (reg_addr)
                `EBT_REG_CTRL: reg_rdata_q <= {30'h0, mode_q};
                `EBT_REG_SELECT: reg_rdata_q <= {26'h0, event_select_register};
                `EBT_REG_DELAY: reg_rdata_q <= {21'h0, trigger_delay_setting};
                `EBT_REG_TRMODE: reg_rdata_q <= {30'h0, trace_mode_select};
                `EBT_REG_QUAL: reg_rdata_q <= {26'h0, qualified_trace_select};
                `EBT_REG_WIN_EN: reg_rdata_q <= {26'h0, win_en_q};
                `EBT_REG_WIN_DIS: reg_rdata_q <= {26'h0, win_dis_q};
                `EBT_REG_STATUS: reg_rdata_q <= status_word;
                `EBT_REG_TRPTR: reg_rdata_q <= {21'h0, wptr_q};
                `EBT_REG_TRIGPTR: reg_rdata_q <= {21'h0, trig_ptr_q};
                default: reg_rdata_q <= (slot != 3'h6) ? {10'h0, cond_q[slot]} : 32'h0;
            endcase
        end else
            reg_rdata_q <= 32'h0;
    end
endmodule // ebt_break_trace

// [testbench/ebt_break_trace_asserts.sv]
`timescale 1ns/10ps
`include "ebt_map.vh"
module ebt_break_trace_asserts (
    input wire clk_sys,
    input wire rst,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata_q,
    input wire tgt_invalid_access,
    input wire tgt_run_q,
    input wire tgt_reset_q,
    input wire tracing_q
);
    // ----------------
    // break checks
    // ----------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // control writes decoded once, shared by the break checks
    wire ctl_wr = reg_wr && (reg_addr == `EBT_REG_CTRL);
    property p_rst; disable iff (1'b0) rst |=> !(tgt_run_q || tgt_reset_q || tracing_q); endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_rdz; !reg_rd |=> reg_rdata_q == 32'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("read data without a read");
    property p_inv; tgt_invalid_access |=> !tgt_run_q && !tracing_q; endproperty
    a_inv: assert property (p_inv) else $error("invalid access did not stop");
    property p_clr; ctl_wr && reg_wdata[4] && tgt_run_q && !tgt_invalid_access
        |=> tgt_reset_q && !tgt_run_q && !tracing_q; endproperty
    a_clr: assert property (p_clr) else $error("clear did not stop and reset");
    property p_clsrc; $rose(tgt_reset_q) |-> $past(ctl_wr) && $past(reg_wdata[4]); endproperty
    a_clsrc: assert property (p_clsrc) else $error("target reset without clear");
    property p_pulse; tgt_reset_q |=> !tgt_reset_q; endproperty
    a_pulse: assert property (p_pulse) else $error("target reset longer than one cycle");
    property p_halt; ctl_wr && reg_wdata[3] && tgt_run_q |=> !tgt_run_q && !tracing_q; endproperty
    a_halt: assert property (p_halt) else $error("halt did not stop run");
    property p_runsrc; $rose(tgt_run_q) |-> $past(ctl_wr); endproperty
    a_runsrc: assert property (p_runsrc) else $error("run began without a request");
    property p_stop; $fell(tgt_run_q) |-> !tracing_q; endproperty
    a_stop: assert property (p_stop) else $error("tracer left running at stop");
endmodule // ebt_break_trace_asserts
bind ebt_break_trace ebt_break_trace_asserts i_chk (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .tgt_invalid_access(tgt_invalid_access),
    .tgt_run_q(tgt_run_q), .tgt_reset_q(tgt_reset_q), .tracing_q(tracing_q)
);

// [testbench/ebt_target_model.sv]
`timescale 1ns/10ps
module ebt_target_model (
    input wire clk_sys,
    input wire rst,
    input wire tgt_run_q,
    output wire tgt_insn_done,
    output wire tgt_data_valid,
    output reg [15:0] pc_q
);
    reg cnt_q;
    // one instruction every second cycle, none while stopped, so a halt is visible on pc_q
    assign tgt_insn_done = tgt_run_q && cnt_q;
    assign tgt_data_valid = tgt_insn_done;
    // program counter advances after each completed instruction
    always @(posedge clk_sys) begin
        if (rst) begin
            cnt_q <= 1'b0;
            pc_q <= 16'h0000;
        end else begin
            cnt_q <= ~cnt_q;
            if (tgt_insn_done) begin
                pc_q <= pc_q + 16'h0001;
            end
        end
    end
endmodule // ebt_target_model

// [testbench/ebt_break_trace_tb.sv]
`timescale 1ns/10ps
`include "ebt_map.vh"
module ebt_break_trace_tb;
    reg clk_sys, rst, reg_wr, reg_rd, tgt_invalid_access;
    reg [3:0] reg_addr;
    reg [31:0] reg_wdata, v;
    reg [10:0] rd_frame;
    reg [15:0] x;
    reg [57:0] fd;
    wire [31:0] reg_rdata_q;
    wire [57:0] rd_frame_data_q;
    wire tgt_run_q, tgt_reset_q, tracing_q, tgt_insn_done, tgt_data_valid;
    wire [15:0] pc;
    integer n_errors, n_tests;
    // ----------------
    // design and target
    // ----------------
    ebt_target_model i_tgt (.clk_sys(clk_sys), .rst(rst), .tgt_run_q(tgt_run_q),
        .tgt_insn_done(tgt_insn_done), .tgt_data_valid(tgt_data_valid), .pc_q(pc));
    // data fields derived from pc so every frame is predictable; data value inverts while tgt_data_valid is high
    ebt_break_trace i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .tgt_insn_done(tgt_insn_done), .tgt_is_call(1'b0), .tgt_is_ret(1'b0),
        .program_address_field(pc), .program_word_field(pc[7:0] ^ 8'h5a),
        .tgt_data_valid(tgt_data_valid), .data_address_field(pc[11:0]),
        .data_value_field(tgt_data_valid ? ~pc[7:0] : pc[7:0]),
        .access_type_field((pc[1:0] == 2'h0) ? 2'h1 : pc[1:0]), .port_value_field(pc[3:0]),
        .clip_input_field(pc[15:8]), .tgt_invalid_access(tgt_invalid_access),
        .tgt_run_q(tgt_run_q), .tgt_reset_q(tgt_reset_q), .tracing_q(tracing_q),
        .rd_frame(rd_frame), .rd_frame_data_q(rd_frame_data_q));
    // expected frame for the instruction at address p
    function [57:0] frm(input [15:0] p);
        frm = {p, p[7:0] ^ 8'h5a, p[11:0], ~p[7:0],
            (p[1:0] == 2'h0) ? `EBT_ACC_READ : p[1:0], p[3:0], p[15:8]};
    endfunction
    task chk(input [63:0] seen, input [63:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        // an idle cycle keeps the strobe to one assignment per time step
        @(posedge clk_sys);
    endtask
    task rd(input [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        v = reg_rdata_q;
    endtask
    task rdf(input [10:0] f);
        rd_frame <= f;
        repeat (2) @(posedge clk_sys);
        fd = rd_frame_data_q;
    endtask
    // bounded wait: 0 run low, 1 tracing low, 2 pc reaches p
    task wt(input [1:0] s, input [15:0] p);
        integer n;
        n = 0;
        @(posedge clk_sys);
        while (n < 6000 && ((s == 2'h0) ? tgt_run_q !== 1'b0 :
            (s == 2'h1) ? tracing_q !== 1'b0 : pc !== p)) begin
            @(posedge clk_sys);
            n = n + 1;
        end
        if (n == 6000)
            n_errors = n_errors + 1;
    endtask
    // fresh reset, one condition register, selection, delay, then the control word
    task cfg(input [3:0] ci, input [15:0] cv, input [5:0] sel, input [10:0] dl, input [6:0] c);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk({tgt_run_q, tgt_reset_q, tracing_q}, 3'h0);
        wr(ci, {16'h0, cv});
        wr(`EBT_REG_SELECT, {26'h0, sel});
        wr(`EBT_REG_DELAY, {21'h0, dl});
        wr(`EBT_REG_CTRL, {25'h0, c});
    endtask
    task t_cond_step;
        cfg(4'he, 16'h0010, 6'h10, 11'h0, 7'h05);
        wt(2'h0, 16'h0);
        chk(tracing_q, 1'b0);
        chk(pc, 16'h0011);
        rd(`EBT_REG_STATUS);
        chk(v[7:5], 3'h1);
        rd(`EBT_REG_TRIGPTR);
        rdf(v[10:0]);
        chk(fd, frm(16'h0010));
        x = pc;
        wr(`EBT_REG_CTRL, 32'h22);
        wt(2'h0, 16'h0);
        chk(pc, x + 16'h1);
        rdf(11'h0);
        chk(fd, frm(x));
        rdf(11'h1);
        chk(fd, 58'h0);
    endtask
    task t_free_halt;
        cfg(4'he, 16'h0020, 6'h10, 11'h3, 7'h04);
        wt(2'h1, 16'h0);
        repeat (6) @(posedge clk_sys);
        chk(tgt_run_q, 1'b1);
        rdf(11'h23);
        chk(fd, frm(16'h0023));
        rdf(11'h24);
        chk(fd, 58'h0);
        wr(`EBT_REG_CTRL, 32'h8);
        @(posedge clk_sys);
        chk({tgt_run_q, tracing_q}, 2'h0);
        // middle delay: as many frames after the trigger as the half memory
        cfg(4'he, 16'h0010, 6'h10, `EBT_TR_HALF, 7'h04);
        wt(2'h1, 16'h0);
        rd(`EBT_REG_TRIGPTR);
        chk(v[10:0], 11'h010);
        rdf(11'h410);
        chk(fd, frm(16'h0410));
        rdf(11'h411);
        chk(fd, 58'h0);
    endtask
    // sectional window opened by a wildcard data condition, closed by a program address
    task t_sect;
        cfg(4'he, 16'h000c, 6'h00, 11'h0, 7'h00);
        wr(4'ha, 32'h003dc008);
        wr(`EBT_REG_TRMODE, 32'h2);
        wr(`EBT_REG_WIN_EN, 32'h1);
        wr(`EBT_REG_WIN_DIS, 32'h10);
        wr(`EBT_REG_CTRL, 32'h4);
        wt(2'h2, 16'h0010);
        wr(`EBT_REG_CTRL, 32'h8);
        rdf(11'h0);
        chk(fd, frm(16'h0008));
        rdf(11'h4);
        chk(fd, frm(16'h000c));
        rdf(11'h5);
        chk(fd, 58'h0);
    endtask
    task t_inv_clear;
        cfg(4'hf, 16'hffff, 6'h20, 11'h0, 7'h05);
        repeat (5) @(posedge clk_sys);
        tgt_invalid_access <= 1'b1;
        reg_addr <= `EBT_REG_CTRL;
        reg_wdata <= 32'h10;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        {tgt_invalid_access, reg_wr} <= 2'h0;
        @(posedge clk_sys);
        chk({tgt_run_q, tracing_q}, 2'h0);
        rd(`EBT_REG_STATUS);
        chk(v[7:5], 3'h4);
        cfg(4'hf, 16'hffff, 6'h20, 11'h0, 7'h04);
        repeat (5) @(posedge clk_sys);
        wr(`EBT_REG_CTRL, 32'h10);
        chk({tgt_reset_q, tgt_run_q, tracing_q}, 3'h4);
        @(posedge clk_sys);
        chk(tgt_reset_q, 1'b0);
    endtask
    // the second mode write must win; wrap test overwrites the oldest frames
    task t_qual_wrap;
        cfg(4'he, 16'h0030, 6'h20, 11'h0, 7'h00);
        wr(4'hf, 32'hffff);
        wr(`EBT_REG_TRMODE, 32'h2);
        wr(`EBT_REG_TRMODE, 32'h1);
        wr(`EBT_REG_QUAL, 32'h10);
        wr(`EBT_REG_CTRL, 32'h4);
        wt(2'h2, 16'h0040);
        wr(`EBT_REG_CTRL, 32'h8);
        rdf(11'h0);
        chk(fd, frm(16'h0030));
        rdf(11'h1);
        chk(fd, 58'h0);
        cfg(4'hf, 16'hffff, 6'h20, 11'h0, 7'h04);
        wt(2'h2, 16'h0810);
        wr(`EBT_REG_CTRL, 32'h8);
        rdf(11'h5);
        chk(fd, frm(16'h0805));
        rdf(11'h20);
        chk(fd, frm(16'h0020));
    endtask
    task report_and_stop;
        if (n_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // watchdog well beyond the roughly seven thousand cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors = n_errors + 1;
        report_and_stop;
    end
    initial begin
        {rst, reg_wr, reg_rd, tgt_invalid_access} = 4'h8;
        {reg_addr, reg_wdata, rd_frame} = 47'h0;
        n_errors = 0;
        n_tests = 0;
        repeat (12) @(posedge clk_sys);
        t_cond_step;
        t_free_halt;
        t_inv_clear;
        t_qual_wrap;
        t_sect;
        report_and_stop;
    end
endmodule // ebt_break_trace_tb
